// >>> hw/dbr_consts.svh
// Constants of the two-channel DMA bus and request mode control.
// Assumes inclusion by bare name from the package and the design files.
`ifndef DBR_CONSTS_SVH
`define DBR_CONSTS_SVH

// Request source encodings
`define DBR_SRC_AUTO   2'h0
`define DBR_SRC_EXT    2'h1
`define DBR_SRC_PERI   2'h2
`define DBR_SRC_RSVD   2'h3

// Unit size code 16 bytes, and beats of one unit
`define DBR_SIZE_16    2'h3
`define DBR_BEATS_16   3'h4
`define DBR_BEATS_1    3'h1
`define DBR_BEATS_0    3'h0

// Bus-free cycles after a release
`define DBR_GAP_CPU    2'h2
`define DBR_GAP_MIN    2'h1

// Data path
`define DBR_DATA_W     32
`define DBR_BUF_DEPTH  2

// State codes
`define DBR_ST_IDLE    3'h0
`define DBR_ST_REQ     3'h1
`define DBR_ST_RD      3'h2
`define DBR_ST_WR      3'h3
`define DBR_ST_SGL     3'h4
`define DBR_ST_NXT     3'h5
`define DBR_ST_REL     3'h6

`endif

// >>> hw/dbr_pkg.sv
// Types of the DMA bus and request mode control.
// Assumes dbr_consts.svh on the include path.
`include "dbr_consts.svh"

package dbr_pkg;

  typedef enum logic [2:0] {
    DBR_IDLE = `DBR_ST_IDLE,
    DBR_REQ  = `DBR_ST_REQ,
    DBR_RD   = `DBR_ST_RD,
    DBR_WR   = `DBR_ST_WR,
    DBR_SGL  = `DBR_ST_SGL,
    DBR_NXT  = `DBR_ST_NXT,
    DBR_REL  = `DBR_ST_REL
  } dbr_state_t;

endpackage

// >>> hw/dbr_buf.sv
// Small valid/ready FIFO holding read data until its write cycle.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module dbr_buf #(
  parameter int W = 32,
  parameter int D = 2
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [CW-1:0] count;
  logic          push;
  logic          pop;

  assign in_ready  = (count != CW'(D));
  assign out_valid = (count != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (push) begin
        wptr <= (wptr == AW'(D - 1)) ? '0 : wptr + AW'(1);
      end
      if (pop) begin
        rptr <= (rptr == AW'(D - 1)) ? '0 : rptr + AW'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (push && !pop) begin
      count <= count + CW'(1);
    end else if (pop && !push) begin
      count <= count - CW'(1);
    end
  end

endmodule

`default_nettype wire

// >>> hw/dbr_mode_ctrl.sv
// Request source, bus mode and acknowledge placement of a two-channel DMA.
// Assumes a bus arbiter answering bus_req with bus_grant, and a bus cycle
// engine that runs each requested cycle and pulses cyc_done at its end.
//
// Behaviour
// RULE1: each channel takes requests only from its selected source.
// RULE2: serial port request source needs that port's data register in use.
// RULE3: dual address acknowledge only in read or write cycle, per select bit.
// RULE4: per channel bus mode select picks cycle-steal or burst.
// RULE5: cycle-steal releases the bus after every unit, re-requests later.
// RULE6: sixteen byte dual address unit keeps the bus for the whole unit.
// RULE7: cycle-steal refused only for peripheral-to-peripheral transfers.
// RULE8: write-cycle acknowledge or single address leaves CPU two bus slots.
// RULE9: software avoids sixteen byte units with level requests in cycle-steal.
// RULE10: burst keeps the bus until the transfer end condition.
// RULE11: level request negated in burst releases after current cycle.
// RULE12: peripheral request source always runs cycle-steal.
// RULE13: software limits burst length to fit the refresh period.
// RULE14: software uses edge sensing for external requests in burst.
// RULE15: memory transfers allow 1/2/4/16 bytes; peripheral requests 1/2/4.
// RULE16: peripheral source or destination allows only 1/2/4 byte units.
// RULE17: single address needs the external request pin as source.
// RULE18: software uses sixteen byte units only with edge sensing.
// RULE19: bus requested before each tenure and dropped at release.
`timescale 1ns/1ps
`default_nettype none
`include "dbr_consts.svh"

module dbr_mode_ctrl (
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic [1:0]      chan_enable,
  input  wire logic [1:0][1:0] req_src_select,
  input  wire logic [1:0]      ext_xfer_req_in,
  input  wire logic [1:0]      periph_req,
  input  wire logic [1:0]      req_sense_select,
  input  wire logic [1:0]      bus_mode_select,
  input  wire logic [1:0]      ack_cycle_select,
  input  wire logic [1:0]      unit_size_hi,
  input  wire logic [1:0]      unit_size_lo,
  input  wire logic [1:0]      single_addr_select,
  input  wire logic [1:0]      src_is_periph,
  input  wire logic [1:0]      dst_is_periph,
  input  wire logic [1:0]      xfer_end,
  output logic                 bus_req,
  input  wire logic            bus_grant,
  output logic                 cyc_req,
  output logic                 cyc_write,
  output logic                 cyc_chan,
  input  wire logic            cyc_done,
  input  wire logic [31:0]     rd_data,
  output logic      [31:0]     wr_data,
  output logic      [1:0]      xfer_ack_out,
  output logic      [1:0]      unit_done,
  output logic      [1:0]      cfg_err,
  output logic                 busy
);

  dbr_pkg::dbr_state_t state;
  dbr_pkg::dbr_state_t next_state;

  logic       cur;
  logic       next_cur;
  logic [2:0] rd_left;
  logic [2:0] wr_left;
  logic [1:0] gap;
  logic [1:0] ext_prev;
  logic [1:0] pend;
  logic [1:0] live;
  logic [1:0] take;
  logic [1:0] eff_burst;
  logic [1:0] next_cfg_err;
  logic       buf_in_ready;
  logic       buf_out_valid;
  logic       buf_pop;
  logic       buf_push;
  logic       unit_end;
  logic       keep;
  logic       start;

  // Settings of the channel that owns the engine
  logic [1:0] c_src;
  logic       c_single;
  logic       c_ack_wr;
  logic       c_burst;
  logic       c_edge;
  logic       c_size16;
  logic [2:0] c_beats;

  assign c_src    = req_src_select[cur];
  assign c_single = single_addr_select[cur];
  assign c_ack_wr = ack_cycle_select[cur];
  assign c_burst  = eff_burst[cur];
  assign c_edge   = req_sense_select[cur];
  assign c_size16 = {unit_size_hi[cur], unit_size_lo[cur]} == `DBR_SIZE_16;
  assign c_beats  = c_size16 ? `DBR_BEATS_16 : `DBR_BEATS_1;

  for (genvar c = 0; c < 2; c++) begin : g_chan
    logic src_ext;
    logic src_peri;
    logic size16;
    logic periph_end;

    assign src_ext    = req_src_select[c] == `DBR_SRC_EXT;
    assign src_peri   = req_src_select[c] == `DBR_SRC_PERI;
    assign size16     = {unit_size_hi[c], unit_size_lo[c]} == `DBR_SIZE_16;
    assign periph_end = src_is_periph[c] | dst_is_periph[c];

    // Peripheral requests never burst
    assign eff_burst[c] = bus_mode_select[c] & ~src_peri; // see RULE12 RULE4

    assign next_cfg_err[c] =
        (req_src_select[c] == `DBR_SRC_RSVD)
      | (single_addr_select[c] & ~src_ext) // see RULE17
      | (single_addr_select[c] & periph_end) // see RULE17
      | (size16 & (src_peri | periph_end)) // see RULE15 RULE16
      | (src_is_periph[c] & dst_is_periph[c] & ~eff_burst[c]); // see RULE7

    // Only the selected source can raise a request
    always_comb begin
      live[c] = 1'b0;
      case (req_src_select[c])
        `DBR_SRC_AUTO: live[c] = 1'b1; // see RULE1
        `DBR_SRC_EXT:  live[c] = req_sense_select[c] ? pend[c] : ext_xfer_req_in[c];
        `DBR_SRC_PERI: live[c] = pend[c]; // see RULE1
        default:       live[c] = 1'b0;
      endcase
      live[c] = live[c] & chan_enable[c] & ~cfg_err[c] & ~xfer_end[c];
    end

    // A new edge in the same cycle as the take is kept
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        pend[c] <= 1'b0;
      end else begin
        pend[c] <= (src_ext & req_sense_select[c] & ext_xfer_req_in[c] & ~ext_prev[c])
                 | (src_peri & periph_req[c])
                 | (pend[c] & ~take[c]);
      end
    end

    assign take[c] = start & (next_cur == 1'(c));
    assign unit_done[c] = unit_end & (cur == 1'(c));
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_prev <= 2'h0;
    end else begin
      ext_prev <= ext_xfer_req_in;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_err <= 2'h0;
    end else begin
      cfg_err <= next_cfg_err;
    end
  end

  assign unit_end = ((state == dbr_pkg::DBR_WR) || (state == dbr_pkg::DBR_SGL))
                  & cyc_done & (wr_left == `DBR_BEATS_1);

  // Burst goes on unless ended or a level request fell
  assign keep = c_burst & chan_enable[cur] & ~xfer_end[cur] & ~cfg_err[cur] // see RULE10
              & ~((c_src == `DBR_SRC_EXT) & ~c_edge & ~ext_xfer_req_in[cur]); // see RULE11

  always_comb begin
    next_state = state;
    next_cur   = cur;
    start      = 1'b0;
    case (state)
      dbr_pkg::DBR_IDLE: begin
        // Fixed order here; channel 0 goes before channel 1
        if (live[0]) begin
          next_cur   = 1'b0;
          start      = 1'b1;
          next_state = dbr_pkg::DBR_REQ;
        end else if (live[1]) begin
          next_cur   = 1'b1;
          start      = 1'b1;
          next_state = dbr_pkg::DBR_REQ;
        end
      end
      dbr_pkg::DBR_REQ: begin
        if (bus_grant) begin
          next_state = c_single ? dbr_pkg::DBR_SGL : dbr_pkg::DBR_RD;
        end
      end
      dbr_pkg::DBR_RD: begin
        // Read ahead while the buffer was empty, so both entries get used
        if (cyc_done) begin
          if ((rd_left > `DBR_BEATS_1) && !buf_out_valid) begin
            next_state = dbr_pkg::DBR_RD;
          end else begin
            next_state = dbr_pkg::DBR_WR;
          end
        end
      end
      dbr_pkg::DBR_WR: begin
        if (cyc_done) begin
          if (wr_left == `DBR_BEATS_1) begin
            next_state = dbr_pkg::DBR_NXT;
          end else if (rd_left != `DBR_BEATS_0) begin
            next_state = dbr_pkg::DBR_RD; // see RULE6
          end
        end
      end
      dbr_pkg::DBR_SGL: begin
        if (cyc_done && (wr_left == `DBR_BEATS_1)) begin
          next_state = dbr_pkg::DBR_NXT;
        end
      end
      dbr_pkg::DBR_NXT: begin
        // Cycle-steal always lets go here
        if (keep) begin
          start      = 1'b1;
          next_state = c_single ? dbr_pkg::DBR_SGL : dbr_pkg::DBR_RD; // see RULE10
        end else begin
          next_state = dbr_pkg::DBR_REL; // see RULE5 RULE11 RULE12
        end
      end
      dbr_pkg::DBR_REL: begin
        if (gap == `DBR_GAP_MIN) begin
          next_state = dbr_pkg::DBR_IDLE;
        end
      end
      default: next_state = dbr_pkg::DBR_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= dbr_pkg::DBR_IDLE;
      cur   <= 1'b0;
    end else begin
      state <= next_state;
      cur   <= next_cur;
    end
  end

  // Beat counters; a sixteen byte unit is four beats
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_left <= `DBR_BEATS_0;
      wr_left <= `DBR_BEATS_0;
    end else if (((state == dbr_pkg::DBR_REQ) && bus_grant)
              || ((state == dbr_pkg::DBR_NXT) && keep)) begin
      rd_left <= c_single ? `DBR_BEATS_0 : c_beats;
      wr_left <= c_beats;
    end else if (cyc_done && cyc_req) begin
      if (state == dbr_pkg::DBR_RD) begin
        rd_left <= rd_left - 3'h1;
      end else begin
        wr_left <= wr_left - 3'h1;
      end
    end
  end

  // Idle bus slots left to the CPU after each release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gap <= `DBR_GAP_MIN;
    end else if ((state == dbr_pkg::DBR_NXT) && !keep) begin
      gap <= (c_ack_wr | c_single) ? `DBR_GAP_CPU : `DBR_GAP_MIN; // see RULE8
    end else if ((state == dbr_pkg::DBR_REL) && (gap != `DBR_GAP_MIN)) begin
      gap <= gap - 2'h1;
    end
  end

  // Held from the request up to the release
  assign bus_req = (state == dbr_pkg::DBR_REQ) || (state == dbr_pkg::DBR_RD) // see RULE19
                || (state == dbr_pkg::DBR_WR) || (state == dbr_pkg::DBR_SGL)
                || (state == dbr_pkg::DBR_NXT);

  // A read waits for buffer room, a write for buffered data
  assign cyc_req = ((state == dbr_pkg::DBR_RD) && buf_in_ready)
                || ((state == dbr_pkg::DBR_WR) && buf_out_valid)
                || (state == dbr_pkg::DBR_SGL);
  assign cyc_write = (state == dbr_pkg::DBR_WR);
  assign cyc_chan  = cur;
  assign busy      = (state != dbr_pkg::DBR_IDLE);

  always_comb begin
    xfer_ack_out = 2'h0;
    if (cyc_req && (c_single || (cyc_write == c_ack_wr))) begin // see RULE3
      xfer_ack_out[cur] = 1'b1;
    end
  end

  assign buf_push = (state == dbr_pkg::DBR_RD) && cyc_done && buf_in_ready;
  assign buf_pop  = (state == dbr_pkg::DBR_WR) && cyc_done;

  dbr_buf #(
    .W (`DBR_DATA_W),
    .D (`DBR_BUF_DEPTH)
  ) u_buf (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (buf_push),
    .in_ready  (buf_in_ready),
    .in_data   (rd_data),
    .out_valid (buf_out_valid),
    .out_ready (buf_pop),
    .out_data  (wr_data)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_cs_end;
    (state == dbr_pkg::DBR_NXT) && !c_burst;
  endsequence

  sequence s_quiet3;
    !bus_req [*3];
  endsequence

  property p_req_cause;
    $rose(bus_req) |-> $past((state == dbr_pkg::DBR_IDLE) && (live != 2'h0));
  endproperty
  a_req_cause: assert property (p_req_cause) else $error("bus request without a live source"); // see RULE1

  property p_ack_cycle;
    (xfer_ack_out != 2'h0) |-> $onehot(xfer_ack_out) && xfer_ack_out[cur]
      && ((state == dbr_pkg::DBR_SGL)
        || ((state == dbr_pkg::DBR_RD) && !ack_cycle_select[cur])
        || ((state == dbr_pkg::DBR_WR) && ack_cycle_select[cur]));
  endproperty
  a_ack_cycle: assert property (p_ack_cycle) else $error("acknowledge in the wrong cycle"); // see RULE3

  property p_cs_release;
    s_cs_end |=> !bus_req;
  endproperty
  a_cs_release: assert property (p_cs_release) else $error("cycle-steal kept the bus"); // see RULE5

  property p_unit16_hold;
    ((state == dbr_pkg::DBR_RD) && cyc_done && !c_single && c_size16) |=> bus_req [*2];
  endproperty
  a_unit16_hold: assert property (p_unit16_hold) else $error("bus dropped inside a unit"); // see RULE6

  property p_cpu_gap;
    ($fell(bus_req) && (c_single || c_ack_wr)) |-> s_quiet3;
  endproperty
  a_cpu_gap: assert property (p_cpu_gap) else $error("CPU gap too short"); // see RULE8

  property p_burst_keep;
    ((state == dbr_pkg::DBR_NXT) && c_burst && (c_src == `DBR_SRC_AUTO)
      && chan_enable[cur] && !xfer_end[cur] && !cfg_err[cur])
      |=> bus_req && ((state == dbr_pkg::DBR_RD) || (state == dbr_pkg::DBR_SGL));
  endproperty
  a_burst_keep: assert property (p_burst_keep) else $error("burst let go early"); // see RULE10

  property p_level_drop;
    ((state == dbr_pkg::DBR_NXT) && (c_src == `DBR_SRC_EXT) && !c_edge
      && !ext_xfer_req_in[cur]) |=> !bus_req ##1 !bus_req;
  endproperty
  a_level_drop: assert property (p_level_drop) else $error("negated level kept the bus"); // see RULE11

  property p_periph_cs;
    ((state == dbr_pkg::DBR_NXT) && (c_src == `DBR_SRC_PERI)) |=> !bus_req;
  endproperty
  a_periph_cs: assert property (p_periph_cs) else $error("peripheral request burst"); // see RULE12

  property p_cfg_block;
    ((state == dbr_pkg::DBR_IDLE) && (cfg_err != 2'h0)) |=> !(bus_req && cfg_err[cur]);
  endproperty
  a_cfg_block: assert property (p_cfg_block) else $error("bad setting started a tenure"); // see RULE7 RULE15 RULE16 RULE17

  property p_req_hold;
    ((state == dbr_pkg::DBR_REQ) && !bus_grant) |=> bus_req && !cyc_req;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped before grant"); // see RULE19

endmodule

`default_nettype wire

// >>> tb/dbr_bus_model.sv
// Far side model: shared bus arbiter and bus cycle engine.
// Assumes the mode control on the same clock and async reset.
`timescale 1ns/1ps
`default_nettype none

module dbr_bus_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [1:0]  slow,
  input  wire logic        bus_req,
  input  wire logic        cyc_req,
  input  wire logic        cyc_write,
  output logic             bus_grant,
  output logic             cyc_done,
  output logic      [31:0] rd_data
);
  logic [1:0]  wait_cnt;
  logic [31:0] word;

  // Grant lags the request by one cycle, drops after release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_grant <= 1'b0;
    end else begin
      bus_grant <= bus_req;
    end
  end

  // Cycle ends after slow wait cycles, pulse is one cycle wide
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cyc_done <= 1'b0;
      wait_cnt <= 2'h0;
    end else if (cyc_req && !cyc_done && wait_cnt >= slow) begin
      cyc_done <= 1'b1;
      wait_cnt <= 2'h0;
    end else begin
      cyc_done <= 1'b0;
      wait_cnt <= cyc_req ? wait_cnt + 2'h1 : 2'h0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      word <= 32'hA5C30001;
    end else if (cyc_req && cyc_done && !cyc_write) begin
      word <= word + 32'h01010101;
    end
  end

  // Outside a read the data bus shows junk, never a stale word
  assign rd_data = (cyc_req && !cyc_write) ? word : ~word;
endmodule

`default_nettype wire

// >>> tb/dbr_mode_ctrl_tb.sv
// Bench of the DMA bus and request mode control, channel 0 in focus.
// Assumes dbr_bus_model as arbiter and cycle engine on the far side.
`timescale 1ns/1ps
`default_nettype none

module dbr_mode_ctrl_tb;
  typedef struct {
    logic [1:0] src, sz;
    logic       burst, ackw, sgl, sp, dp, sense, neg, err;
    int         tgt, xu, xr;
  } dbr_row_t;
  localparam int UNITS = 0, NRD = 1, NWR = 2, ACKR = 3, ACKW = 4, REL = 5, LOW = 6, GAP = 7;

  logic            clk, rst, bus_req, bus_grant, cyc_req, cyc_write, cyc_chan, cyc_done, busy;
  logic [1:0]      chan_enable, ext_xfer_req_in, periph_req, req_sense_select, bus_mode_select;
  logic [1:0]      ack_cycle_select, unit_size_hi, unit_size_lo, single_addr_select, slow;
  logic [1:0]      src_is_periph, dst_is_periph, xfer_end, xfer_ack_out, unit_done, cfg_err;
  logic [1:0][1:0] req_src_select;
  logic [31:0]     rd_data, wr_data, exp_w;
  logic            run, tgl, neg, prev_req;
  int              fail_count, n_compared, tgt, c[8];
  logic [31:0]     rdq[$];
  dbr_row_t        rows[16];

  dbr_mode_ctrl dbr_mode_ctrl_inst (
    .clk(clk), .rst(rst), .chan_enable(chan_enable), .req_src_select(req_src_select),
    .ext_xfer_req_in(ext_xfer_req_in), .periph_req(periph_req),
    .req_sense_select(req_sense_select), .bus_mode_select(bus_mode_select),
    .ack_cycle_select(ack_cycle_select), .unit_size_hi(unit_size_hi),
    .unit_size_lo(unit_size_lo), .single_addr_select(single_addr_select),
    .src_is_periph(src_is_periph), .dst_is_periph(dst_is_periph), .xfer_end(xfer_end),
    .bus_req(bus_req), .bus_grant(bus_grant), .cyc_req(cyc_req), .cyc_write(cyc_write),
    .cyc_chan(cyc_chan), .cyc_done(cyc_done), .rd_data(rd_data), .wr_data(wr_data),
    .xfer_ack_out(xfer_ack_out), .unit_done(unit_done), .cfg_err(cfg_err), .busy(busy));

  dbr_bus_model dbr_bus_model_inst (
    .clk(clk), .rst(rst), .slow(slow), .bus_req(bus_req), .cyc_req(cyc_req),
    .cyc_write(cyc_write), .bus_grant(bus_grant), .cyc_done(cyc_done), .rd_data(rd_data));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_flag(input logic got, input logic exp);
    cmp_data({31'h0, got}, {31'h0, exp});
  endtask

  // Requester side: edge pins toggle, level pins hold, end flag after target
  always @(posedge clk) begin
    #2;
    tgl = ~tgl;
    xfer_end[0] = run && c[UNITS] >= tgt;
    ext_xfer_req_in[0] = run && !(neg && c[UNITS] >= 1) && (req_sense_select[0] ? tgl : 1'b1);
    periph_req[0] = run && tgl;
  end

  // Mid-cycle monitor of channel 0 traffic and bus tenure
  always @(negedge clk) begin
    if (!rst) begin
      if (unit_done[0] === 1'b1) c[UNITS]++;
      if (cyc_req && cyc_done && cyc_chan === 1'b0) begin
        if (xfer_ack_out[0] === 1'b1) begin
          if (cyc_write) c[ACKW]++;
          else c[ACKR]++;
        end
        if (!cyc_write) begin
          c[NRD]++;
          rdq.push_back(rd_data);
        end else begin
          c[NWR]++;
          exp_w = rdq.size() > 0 ? rdq.pop_front() : ~wr_data;
          cmp_data(wr_data, exp_w);
        end
      end
      if (prev_req && !bus_req) c[REL]++;
      if (!bus_req) c[LOW]++;
      else begin
        if (!prev_req && c[REL] > 0 && c[LOW] < c[GAP]) c[GAP] = c[LOW];
        c[LOW] = 0;
      end
      prev_req = bus_req;
    end
  end

  task automatic setup(input dbr_row_t r, input int idx);
    rst = 1'b1;
    run = 1'b0;
    chan_enable = 2'h0;
    req_src_select = {2'h0, r.src};
    unit_size_hi = {1'b0, r.sz[1]};
    unit_size_lo = {1'b0, r.sz[0]};
    bus_mode_select = {1'b0, r.burst};
    ack_cycle_select = {1'b0, r.ackw};
    single_addr_select = {1'b0, r.sgl};
    src_is_periph = {1'b0, r.sp};
    dst_is_periph = {1'b0, r.dp};
    req_sense_select = {1'b0, r.sense};
    slow = idx[0] ? 2'h2 : 2'h0;
    tgt = r.tgt;
    neg = r.neg;
    foreach (c[k]) c[k] = 0;
    c[GAP] = 99;
    prev_req = 1'b0;
    rdq.delete();
    repeat (2) @(posedge clk);
    #2 rst = 1'b0;
    @(posedge clk);
    #2 run = 1'b1;
    @(posedge clk);
    #2 chan_enable = 2'h1;
  endtask

  task automatic run_row(input dbr_row_t r, input int idx);
    int n;
    n = r.xu * ((r.sz == 2'h3) ? 4 : 1);
    setup(r, idx);
    repeat (20) @(posedge clk);
    for (int i = 0; i < 400 && !(busy === 1'b0 && (r.err || c[UNITS] >= (r.neg ? 1 : tgt))); i++)
      @(posedge clk);
    #2 run = 1'b0;
    cmp_flag(cfg_err[0], r.err);
    cmp_data(32'(c[UNITS]), 32'(r.xu));
    cmp_data(32'(c[REL]), 32'(r.xr));
    cmp_data(32'(c[NRD]), 32'(n));
    cmp_data(32'(c[NWR]), r.sgl ? 32'h0 : 32'(n));
    cmp_data(32'(c[ACKR]), (r.sgl || !r.ackw) ? 32'(n) : 32'h0);
    cmp_data(32'(c[ACKW]), (!r.sgl && r.ackw) ? 32'(n) : 32'h0);
    if (r.xr >= 2) cmp_flag(c[GAP] >= ((r.sgl || r.ackw) ? 3 : 2), 1'b1);
  endtask

  initial begin
    fail_count = 0;
    n_compared = 0;
    rst = 1'b1;
    {chan_enable, ext_xfer_req_in, periph_req, req_sense_select, bus_mode_select} = '0;
    {ack_cycle_select, unit_size_hi, unit_size_lo, single_addr_select, slow} = '0;
    {src_is_periph, dst_is_periph, xfer_end, req_src_select} = '0;
    {run, tgl, neg, prev_req, tgt} = '0;
    rows = '{
      '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 2, 2, 2},
      '{0, 2, 1, 1, 0, 0, 0, 0, 0, 0, 3, 3, 1},
      '{0, 3, 0, 0, 0, 0, 0, 0, 0, 0, 2, 2, 2},
      '{1, 1, 0, 1, 0, 0, 0, 1, 0, 0, 2, 2, 2},
      '{1, 3, 1, 0, 1, 0, 0, 1, 0, 0, 2, 2, 1},
      '{1, 0, 0, 0, 1, 0, 0, 1, 0, 0, 2, 2, 2},
      '{1, 0, 1, 0, 0, 0, 0, 0, 1, 0, 3, 1, 1},
      '{1, 2, 0, 0, 0, 0, 0, 0, 0, 0, 2, 2, 2},
      '{2, 1, 1, 0, 0, 1, 0, 0, 0, 0, 2, 2, 2},
      '{2, 0, 0, 0, 0, 1, 1, 0, 0, 1, 2, 0, 0},
      '{3, 0, 0, 0, 0, 0, 0, 0, 0, 1, 2, 0, 0},
      '{0, 0, 0, 0, 1, 0, 0, 0, 0, 1, 2, 0, 0},
      '{2, 3, 0, 0, 0, 1, 0, 0, 0, 1, 2, 0, 0},
      '{0, 3, 1, 0, 0, 0, 1, 0, 0, 1, 2, 0, 0},
      '{0, 0, 1, 0, 0, 1, 1, 0, 0, 0, 2, 2, 1},
      '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0}
    };
    repeat (16) @(posedge clk);
    for (int i = 0; i < 16; i++) run_row(rows[i], i);
    // Channel 1 alone, while channel 0 holds a reserved source
    setup(rows[10], 10);
    @(posedge clk);
    #2 chan_enable = 2'h3;
    while (cyc_req !== 1'b1) @(negedge clk);
    cmp_flag(cyc_chan, 1'b1);
    cmp_data(32'(xfer_ack_out), 32'h2);
    // Reset in mid-burst must drop the bus at once
    setup(rows[1], 1);
    repeat (6) @(posedge clk);
    #2 cmp_flag(busy, 1'b1);
    #3 rst = 1'b1;
    #1 cmp_flag(bus_req | busy | cyc_req | (|xfer_ack_out) | (|unit_done) | (|cfg_err), 1'b0);
    finish_test();
  end

  // Whole run is under 7000 cycles; cut off well beyond that
  initial begin
    #(25 * 30000);
    fail_count++;
    finish_test();
  end
endmodule

`default_nettype wire
